//--- fspu_core.sv
// Flash self-programming front end: registers, write buffer, unlock checker, flash requests.

`default_nettype none

module fspu_core #(
	parameter int LOW_SPEED_INTERNAL_OSCILLATOR_HZ = fspu_pkg::LOW_SPEED_INTERNAL_OSCILLATOR_HZ_DEF
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	input wire logic low_speed_internal_oscillator_tick_in,
	output logic flash_req_out,
	output logic [2:0] flash_op_out,
	output logic [14:0] flash_addr_out,
	output logic flash_wbuf_load_out,
	output logic [15:0] flash_wbuf_data_out,
	output logic flash_wbuf_clear_out,
	input wire logic flash_done_in,
	input wire logic [15:0] flash_rdata_in,
	output logic write_enabled_out,
	output logic chip_reset_out
);

	// ------------------------------------------------------------------
	// Timeout length in oscillator ticks
	// ------------------------------------------------------------------
	// A longest time rounds down, but never below one tick.
	localparam int TICKS_RAW = (fspu_pkg::TIMEOUT_US * LOW_SPEED_INTERNAL_OSCILLATOR_HZ) / 1000000;
	localparam int TICKS = (TICKS_RAW < 1) ? 1 : TICKS_RAW;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic wen_r;
	logic [2:0] mode_r;
	logic unlock_r;
	logic wtrig_r;
	logic rden_r;
	logic rtrig_r;
	logic [7:0] chip_rst_byte_r;
	logic clwb_r;
	logic [14:0] addr_r;
	logic [7:0] data_r [8];
	logic [15:0] wbuf_r;
	fspu_pkg::fspu_ulk_e ulk_r;
	logic [2:0] ulk_idx_r;
	logic [15:0] ulk_ticks_r;
	fspu_pkg::fspu_fop_e fop_r;
	logic fop_is_read_r;

	logic wr_ctrl;
	logic wr_word0_high;
	logic pat_wr;
	logic pat_ok;
	logic ulk_start;
	logic ulk_pass;
	logic ulk_fail;
	logic ulk_expired;
	logic wr_allowed;
	logic rd_allowed;
	logic wtrig_clr;
	logic rtrig_clr;
	logic [7:0] ctrl_view;

	assign wr_ctrl = reg_wr_in && (reg_addr_in == fspu_pkg::OFS_CTRL);
	assign wr_word0_high = reg_wr_in && (reg_addr_in == 8'(fspu_pkg::OFS_DATA_FIRST + 8'h01));

	// ------------------------------------------------------------------
	// Unlock sequence checker
	// ------------------------------------------------------------------
	assign ulk_start = (ulk_r == fspu_pkg::ULK_IDLE) && unlock_r
		&& (mode_r == fspu_pkg::MODE_UNLOCK);
	assign pat_wr = (ulk_r == fspu_pkg::ULK_RUN) && reg_wr_in
		&& (reg_addr_in >= fspu_pkg::OFS_PATTERN_FIRST)
		&& (reg_addr_in <= fspu_pkg::OFS_DATA_LAST);
	// A byte counts only at its own register and with its own value.
	assign pat_ok = (reg_addr_in == 8'(fspu_pkg::OFS_PATTERN_FIRST + {5'h00, ulk_idx_r}))
		&& (reg_wdata_in == fspu_pkg::PATTERN[{ulk_idx_r, 3'b000} +: 8]);
	assign ulk_expired = (ulk_r == fspu_pkg::ULK_RUN) && low_speed_internal_oscillator_tick_in
		&& (ulk_ticks_r >= 16'(TICKS - 1));
	assign ulk_pass = pat_wr && pat_ok && (ulk_idx_r == fspu_pkg::PATTERN_LAST)
		&& !ulk_expired;
	assign ulk_fail = (pat_wr && !pat_ok) || ulk_expired;

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ulk_r <= fspu_pkg::ULK_IDLE;
			ulk_idx_r <= 3'h0;
			ulk_ticks_r <= 16'h0000;
		end else begin
			case (ulk_r)
				fspu_pkg::ULK_IDLE: begin
					ulk_idx_r <= 3'h0;
					ulk_ticks_r <= 16'h0000;
					if (ulk_start) begin
						ulk_r <= fspu_pkg::ULK_RUN;
					end
				end
				fspu_pkg::ULK_RUN: begin
					// Software dropping the procedure bit abandons the attempt.
					if (ulk_pass || ulk_fail || !unlock_r) begin
						ulk_r <= fspu_pkg::ULK_IDLE;
					end else begin
						if (pat_wr) begin
							ulk_idx_r <= ulk_idx_r + 3'h1;
						end
						if (low_speed_internal_oscillator_tick_in) begin
							ulk_ticks_r <= ulk_ticks_r + 16'h0001;
						end
					end
				end
				default: begin
					ulk_r <= fspu_pkg::ULK_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			wen_r <= 1'b0;
		end else if (ulk_pass) begin
			// The hardware set wins over a software clear in the same cycle.
			wen_r <= 1'b1;
		end else if (wr_ctrl && !reg_wdata_in[fspu_pkg::CTL_WEN_BIT]) begin
			wen_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			mode_r <= 3'b000;
			rden_r <= 1'b0;
		end else if (wr_ctrl) begin
			mode_r <= reg_wdata_in[fspu_pkg::CTL_MODE_LSB +: 3];
			rden_r <= reg_wdata_in[fspu_pkg::CTL_RDEN_BIT];
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			unlock_r <= 1'b0;
		end else if (ulk_pass || ulk_fail) begin
			unlock_r <= 1'b0;
		end else if (wr_ctrl) begin
			unlock_r <= reg_wdata_in[fspu_pkg::CTL_UNLOCK_BIT];
		end
	end

	// Triggers: software may only set them, and a set beats a same-cycle clear.
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			wtrig_r <= 1'b0;
			rtrig_r <= 1'b0;
		end else begin
			if (wtrig_clr) begin
				wtrig_r <= 1'b0;
			end
			if (rtrig_clr) begin
				rtrig_r <= 1'b0;
			end
			if (wr_ctrl && reg_wdata_in[fspu_pkg::CTL_WRITE_BIT]) begin
				wtrig_r <= 1'b1;
			end
			if (wr_ctrl && reg_wdata_in[fspu_pkg::CTL_READ_BIT]) begin
				rtrig_r <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Chip reset key and write buffer clear
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			chip_rst_byte_r <= fspu_pkg::RST_BYTE;
			chip_reset_out <= 1'b0;
		end else begin
			chip_reset_out <= reg_wr_in && (reg_addr_in == fspu_pkg::OFS_CHIP_RST)
				&& (reg_wdata_in == fspu_pkg::CHIP_RST_KEY);
			if (reg_wr_in && (reg_addr_in == fspu_pkg::OFS_CHIP_RST)) begin
				chip_rst_byte_r <= reg_wdata_in;
			end
		end
	end

	// The clear takes one cycle, so the bit is seen set for exactly one cycle.
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			clwb_r <= 1'b0;
		end else if (reg_wr_in && (reg_addr_in == fspu_pkg::OFS_BUF_CLR)
			&& reg_wdata_in[fspu_pkg::BUF_CLR_BIT]) begin
			clwb_r <= 1'b1;
		end else begin
			clwb_r <= 1'b0;
		end
	end

	assign flash_wbuf_clear_out = clwb_r;

	// ------------------------------------------------------------------
	// Address pair
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			addr_r <= 15'h0000;
		end else if (reg_wr_in && (reg_addr_in == fspu_pkg::OFS_ADDR_LO)) begin
			addr_r[7:0] <= reg_wdata_in;
		end else if (reg_wr_in && (reg_addr_in == fspu_pkg::OFS_ADDR_HI)) begin
			addr_r[14:8] <= reg_wdata_in[fspu_pkg::ADDR_HI_W-1:0];
		end else if (wr_word0_high) begin
			addr_r <= addr_r + 15'h0001;
		end
	end

	// ------------------------------------------------------------------
	// Data word bytes
	// ------------------------------------------------------------------
	for (genvar i = 0; i < 8; i++) begin : g_data
		always_ff @(posedge clk_sys_in or posedge rst_in) begin
			if (rst_in) begin
				data_r[i] <= fspu_pkg::RST_BYTE;
			end else if (reg_wr_in
				&& (reg_addr_in == 8'(fspu_pkg::OFS_DATA_FIRST + 8'(i)))) begin
				data_r[i] <= reg_wdata_in;
			end else if ((i < 2) && (fop_r == fspu_pkg::FOP_BUSY) && fop_is_read_r
				&& flash_done_in) begin
				data_r[i] <= flash_rdata_in[8*(i%2) +: 8];
			end
		end
	end

	// Only the high byte write moves data into the buffer, both halves at once.
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			wbuf_r <= 16'h0000;
			flash_wbuf_load_out <= 1'b0;
		end else begin
			flash_wbuf_load_out <= wr_word0_high;
			if (wr_word0_high) begin
				wbuf_r <= {reg_wdata_in, data_r[0]};
			end else if (clwb_r) begin
				wbuf_r <= 16'h0000;
			end
		end
	end

	assign flash_wbuf_data_out = wbuf_r;

	// ------------------------------------------------------------------
	// Flash operation sequencing
	// ------------------------------------------------------------------
	// Write and erase go out only while writing is unlocked.
	assign wr_allowed = wen_r && ((mode_r == fspu_pkg::MODE_WRITE)
		|| (mode_r == fspu_pkg::MODE_ERASE));
	assign rd_allowed = rden_r && (mode_r == fspu_pkg::MODE_READ);
	// A trigger that cannot be honoured is dropped at once so software never hangs on it.
	assign wtrig_clr = (fop_r == fspu_pkg::FOP_FINISH && !fop_is_read_r)
		|| (fop_r == fspu_pkg::FOP_IDLE && wtrig_r && !wr_allowed);
	assign rtrig_clr = (fop_r == fspu_pkg::FOP_FINISH && fop_is_read_r)
		|| (fop_r == fspu_pkg::FOP_IDLE && rtrig_r && !wtrig_r && !rd_allowed);

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			fop_r <= fspu_pkg::FOP_IDLE;
			fop_is_read_r <= 1'b0;
			flash_req_out <= 1'b0;
			flash_op_out <= 3'b000;
			flash_addr_out <= 15'h0000;
		end else begin
			flash_req_out <= 1'b0;
			case (fop_r)
				fspu_pkg::FOP_IDLE: begin
					if (wtrig_r && wr_allowed) begin
						fop_r <= fspu_pkg::FOP_BUSY;
						fop_is_read_r <= 1'b0;
						flash_req_out <= 1'b1;
						flash_op_out <= mode_r;
						if (mode_r == fspu_pkg::MODE_ERASE) begin
							// Page number is address bits 14..6 only.
							flash_addr_out <= {addr_r[14:fspu_pkg::PAGE_LSB],
								6'h00};
						end else begin
							flash_addr_out <= addr_r;
						end
					end else if (rtrig_r && !wtrig_r && rd_allowed) begin
						fop_r <= fspu_pkg::FOP_BUSY;
						fop_is_read_r <= 1'b1;
						flash_req_out <= 1'b1;
						flash_op_out <= mode_r;
						flash_addr_out <= addr_r;
					end
				end
				fspu_pkg::FOP_BUSY: begin
					if (flash_done_in) begin
						fop_r <= fspu_pkg::FOP_FINISH;
					end
				end
				fspu_pkg::FOP_FINISH: begin
					fop_r <= fspu_pkg::FOP_IDLE;
				end
				default: begin
					fop_r <= fspu_pkg::FOP_IDLE;
				end
			endcase
		end
	end

	assign write_enabled_out = wen_r;

	// ------------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------------
	assign ctrl_view = {wen_r, mode_r, unlock_r, wtrig_r, rden_r, rtrig_r};

	// Unmapped addresses read as zero; data appears the cycle after the strobe.
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (!reg_rd_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_addr_in == fspu_pkg::OFS_CTRL) begin
			reg_rdata_out <= ctrl_view;
		end else if (reg_addr_in == fspu_pkg::OFS_CHIP_RST) begin
			reg_rdata_out <= chip_rst_byte_r;
		end else if (reg_addr_in == fspu_pkg::OFS_BUF_CLR) begin
			reg_rdata_out <= {7'h00, clwb_r};
		end else if (reg_addr_in == fspu_pkg::OFS_ADDR_LO) begin
			reg_rdata_out <= addr_r[7:0];
		end else if (reg_addr_in == fspu_pkg::OFS_ADDR_HI) begin
			reg_rdata_out <= {1'b0, addr_r[14:8]};
		end else if ((reg_addr_in >= fspu_pkg::OFS_DATA_FIRST)
			&& (reg_addr_in <= fspu_pkg::OFS_DATA_LAST)) begin
			reg_rdata_out <= data_r[reg_addr_in[2:0]];
		end else begin
			reg_rdata_out <= 8'h00;
		end
	end

endmodule

`default_nettype wire

//--- fspu_pkg.sv
// Constants shared by the flash self-programming and write-unlock front end.
//
// Overview of operation
// - Upper address register keeps address bits 14..8; bit 7 reads zero.
// - Writing the first word low byte only stores that byte.
// - Writing the first word high byte loads both bytes into the write buffer.
// - After that buffer load the fifteen-bit address pair increments by one.
// - Second, third and fourth word byte registers are plain read/write, reset zero.
// - Pattern 00,04,0D,09,C3,40 goes into second-low through fourth-high in turn.
// - A 300 us timeout runs from unlock start; pattern must finish before it.
// - The timeout counts ticks of the low-speed internal oscillator.
// - Timeout or wrong byte leaves writing disabled and clears the unlock-procedure bit.
// - Correct pattern enables writing, clears unlock-procedure bit, sets write-enabled status.
// - Software clearing write-enabled status disables writing until a new unlock.
// - Page erase clears one page of 64 words.
// - Erase page comes from upper address and lower bits 7..6 only.
// - Mode 000 write, 001 erase, 011 read, 110 unlock, others reserved.
// - Write trigger is set by software and cleared by hardware on completion.
// - Read trigger is set by software and cleared by hardware on completion.
// - Software writing one to write-enabled status has no effect.

`default_nettype none

package fspu_pkg;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h43;
	localparam logic [7:0] OFS_CHIP_RST = 8'h44;
	localparam logic [7:0] OFS_BUF_CLR = 8'h45;
	localparam logic [7:0] OFS_ADDR_LO = 8'h46;
	localparam logic [7:0] OFS_ADDR_HI = 8'h47;
	localparam logic [7:0] OFS_DATA_FIRST = 8'h48;
	localparam logic [7:0] OFS_DATA_LAST = 8'h4F;
	localparam logic [7:0] OFS_PATTERN_FIRST = 8'h4A;

	// ------------------------------------------------------------------
	// Field positions and values
	// ------------------------------------------------------------------
	localparam int CTL_WEN_BIT = 7;
	localparam int CTL_MODE_LSB = 4;
	localparam int CTL_UNLOCK_BIT = 3;
	localparam int CTL_WRITE_BIT = 2;
	localparam int CTL_RDEN_BIT = 1;
	localparam int CTL_READ_BIT = 0;
	localparam int BUF_CLR_BIT = 0;
	localparam int ADDR_W = 15;
	localparam int ADDR_HI_W = 7;
	localparam int PAGE_LSB = 6;
	localparam int PAGE_WORDS = 64;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] CHIP_RST_KEY = 8'h55;

	localparam logic [2:0] MODE_WRITE = 3'b000;
	localparam logic [2:0] MODE_ERASE = 3'b001;
	localparam logic [2:0] MODE_READ = 3'b011;
	localparam logic [2:0] MODE_UNLOCK = 3'b110;

	// Unlock bytes, first expected byte in the low lane.
	localparam logic [47:0] PATTERN = 48'h40C3090D0400;
	localparam logic [2:0] PATTERN_LAST = 3'h5;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int TIMEOUT_US = 300;
	localparam int LOW_SPEED_INTERNAL_OSCILLATOR_HZ_DEF = 32000;

	typedef enum logic [1:0] {
		ULK_IDLE = 2'b00,
		ULK_RUN = 2'b01
	} fspu_ulk_e;

	typedef enum logic [1:0] {
		FOP_IDLE = 2'b00,
		FOP_BUSY = 2'b01,
		FOP_FINISH = 2'b11
	} fspu_fop_e;

endpackage

`default_nettype wire

//--- fspu_core_chk.sv
// Concurrent checks on the ports of the flash self-programming front end.
`default_nettype none
module fspu_core_chk #(
	parameter int LOW_SPEED_INTERNAL_OSCILLATOR_HZ = fspu_pkg::LOW_SPEED_INTERNAL_OSCILLATOR_HZ_DEF
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic flash_req_out,
	input wire logic [2:0] flash_op_out,
	input wire logic [14:0] flash_addr_out,
	input wire logic flash_wbuf_load_out,
	input wire logic [15:0] flash_wbuf_data_out,
	input wire logic write_enabled_out
);
	default clocking @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);
	chk_upper_bit7: assert property (
		reg_rd_in && reg_addr_in == 8'h47 |=> !reg_rdata_out[7])
		else $error("upper address bit 7 read as one");
	chk_low_no_load: assert property (
		reg_wr_in && reg_addr_in == 8'h48 |=> !flash_wbuf_load_out && $stable(flash_wbuf_data_out))
		else $error("low byte write touched the write buffer");
	chk_high_load: assert property (
		reg_wr_in && reg_addr_in == 8'h49
		|=> flash_wbuf_load_out && flash_wbuf_data_out[15:8] == $past(reg_wdata_in))
		else $error("high byte write did not load the buffer");
	chk_wen_source: assert property (
		$rose(write_enabled_out) |-> $past(reg_wr_in) && $past(reg_addr_in) == 8'h4F
		&& $past(reg_wdata_in) == 8'h40)
		else $error("write enable rose without a final pattern byte");
	chk_wen_clear: assert property (
		reg_wr_in && reg_addr_in == 8'h43 && !reg_wdata_in[7] |=> !write_enabled_out)
		else $error("write enable not cleared by software");
	chk_op_legal: assert property (
		flash_req_out |-> flash_op_out inside {3'b000, 3'b001, 3'b011})
		else $error("flash request with a reserved operation");
	chk_erase_page: assert property (
		flash_req_out && flash_op_out == 3'b001 |-> flash_addr_out[5:0] == 6'h00)
		else $error("erase address not page aligned");
	chk_write_gated: assert property (
		flash_req_out && flash_op_out != 3'b011 |-> $past(write_enabled_out))
		else $error("write or erase issued while writing disabled");
endmodule
bind fspu_core fspu_core_chk #(.LOW_SPEED_INTERNAL_OSCILLATOR_HZ(LOW_SPEED_INTERNAL_OSCILLATOR_HZ)) u_chk (.clk_sys_in(clk_sys_in),
	.rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .flash_req_out(flash_req_out),
	.flash_op_out(flash_op_out), .flash_addr_out(flash_addr_out),
	.flash_wbuf_load_out(flash_wbuf_load_out), .flash_wbuf_data_out(flash_wbuf_data_out),
	.write_enabled_out(write_enabled_out));
`default_nettype wire

//--- fspu_flash_model.sv
// Behavioural flash array that answers the front end after a set delay.
`default_nettype none
module fspu_flash_model (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic req_in,
	input wire logic [2:0] op_in,
	input wire logic [14:0] addr_in,
	input wire logic [15:0] wbuf_in,
	input wire logic [7:0] delay_in,
	output logic done_out,
	output logic [15:0] rdata_out
);
	// Only 256 words are kept; address bits above 7 are ignored to stay small.
	logic [15:0] mem_r [0:255];
	logic [7:0] cnt_r;
	logic busy_r;
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < 256; i++) begin
				mem_r[i] <= {8'hA5 ^ 8'(i), 8'(i)};
			end
			busy_r <= 1'b0;
			cnt_r <= 8'h00;
			done_out <= 1'b0;
			rdata_out <= 16'h0000;
		end else begin
			done_out <= 1'b0;
			// Read data is only valid with done, so it toggles otherwise.
			rdata_out <= ~rdata_out;
			if (req_in && !busy_r) begin
				busy_r <= 1'b1;
				cnt_r <= delay_in;
			end else if (busy_r && cnt_r != 8'h00) begin
				cnt_r <= cnt_r - 8'h01;
			end else if (busy_r) begin
				busy_r <= 1'b0;
				done_out <= 1'b1;
				if (op_in == 3'b001) begin
					for (int i = 0; i < 64; i++) begin
						mem_r[{addr_in[7:6], 6'(i)}] <= 16'hFFFF;
					end
				end else if (op_in == 3'b000) begin
					mem_r[addr_in[7:0]] <= wbuf_in;
				end else begin
					rdata_out <= mem_r[addr_in[7:0]];
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- fspu_core_tb.sv
// Self-checking bench for the flash self-programming front end.
`default_nettype none
module fspu_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [47:0] UNLOCK_SEQ = 48'h40C3090D0400;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic tick = 1'b0;
	logic tick_en = 1'b0;
	logic [7:0] dly = 8'h03;
	logic [3:0] tcnt = 4'h0;
	logic [7:0] rdata;
	logic [7:0] got;
	logic req;
	logic done;
	logic wen;
	logic [2:0] op;
	logic [14:0] faddr;
	logic [15:0] wbd;
	logic [15:0] read_trigger_bit;
	logic ld;
	logic clr;
	logic crst;
	int nreq = 0;
	int fails = 0;
	int total_checks = 0;
	always #12.5 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) begin
		tcnt <= (tcnt == 4'h9) ? 4'h0 : tcnt + 4'h1;
		tick <= tick_en && (tcnt == 4'h9);
		if (req) nreq++;
	end
	fspu_core u_fspu_core (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(addr),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.low_speed_internal_oscillator_tick_in(tick), .flash_req_out(req), .flash_op_out(op), .flash_addr_out(faddr),
		.flash_wbuf_load_out(ld), .flash_wbuf_data_out(wbd), .flash_wbuf_clear_out(clr),
		.flash_done_in(done), .flash_rdata_in(read_trigger_bit), .write_enabled_out(wen),
		.chip_reset_out(crst));
	fspu_flash_model u_fspu_flash_model (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.req_in(req), .op_in(op), .addr_in(faddr), .wbuf_in(wbd), .delay_in(dly),
		.done_out(done), .rdata_out(read_trigger_bit));
	task automatic results();
		if (fails == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_in);
		wr <= 1'b0;
		// Registered outputs launched by this edge are settled one step later.
		#1;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk_sys_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_in);
		rd <= 1'b0;
		#1 got = rdata;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		rd_reg(a);
		chk($sformatf("reg_%h", a), {8'h00, exp}, {8'h00, got});
	endtask
	// Polls the control register until the trigger bits in mask drop.
	task automatic wait_clear(input logic [7:0] mask);
		int n;
		n = 0;
		got = mask;
		while ((got & mask) != 8'h00 && n < 100) begin
			rd_reg(8'h43);
			n++;
		end
		if ((got & mask) != 8'h00) begin
			chk("trigger wait", 16'h0000, {8'h00, got & mask});
			results();
		end
	endtask
	task automatic pattern(input int bad);
		for (int i = 0; i < 6; i++) begin
			wr_reg(8'h4A + 8'(i), UNLOCK_SEQ[8*i +: 8] ^ ((i == bad) ? 8'h01 : 8'h00));
		end
	endtask
	initial begin
		repeat (4) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		for (int a = 8'h43; a <= 8'h50; a++) rd_chk(8'(a), 8'h00);
		wr_reg(8'h47, 8'hFF);
		rd_chk(8'h47, 8'h7F);
		wr_reg(8'h46, 8'hFF);
		wr_reg(8'h48, 8'h34);
		chk("buffer", 16'h0000, wbd);
		chk("buffer load", 16'h0000, {15'h0, ld});
		wr_reg(8'h49, 8'h12);
		chk("buffer", 16'h1234, wbd);
		chk("buffer load", 16'h0001, {15'h0, ld});
		rd_chk(8'h46, 8'h00);
		rd_chk(8'h47, 8'h00);
		wr_reg(8'h46, 8'h3F);
		wr_reg(8'h49, 8'h56);
		chk("buffer", 16'h5634, wbd);
		rd_chk(8'h46, 8'h40);
		for (int i = 0; i < 6; i++) wr_reg(8'h4A + 8'(i), 8'h11 * 8'(i + 1));
		for (int i = 0; i < 6; i++) rd_chk(8'h4A + 8'(i), 8'h11 * 8'(i + 1));
		wr_reg(8'h43, 8'h80);
		rd_chk(8'h43, 8'h00);
		tick_en <= 1'b1;
		wr_reg(8'h43, 8'h68);
		pattern(3);
		rd_chk(8'h43, 8'h60);
		wr_reg(8'h43, 8'h68);
		repeat (120) @(posedge clk_sys_in);
		rd_chk(8'h43, 8'h60);
		pattern(6);
		chk("enabled", 16'h0000, {15'h0, wen});
		tick_en <= 1'b0;
		wr_reg(8'h43, 8'h68);
		// Longer than the timeout in system clocks, so only oscillator ticks may end it.
		repeat (12100) @(posedge clk_sys_in);
		pattern(6);
		rd_chk(8'h43, 8'hE0);
		wr_reg(8'h43, 8'h00);
		wr_reg(8'h43, 8'h04);
		wait_clear(8'h04);
		chk("requests", 16'h0000, 16'(nreq));
		tick_en <= 1'b1;
		wr_reg(8'h43, 8'h68);
		pattern(6);
		chk("enabled", 16'h0001, {15'h0, wen});
		dly <= 8'h14;
		wr_reg(8'h47, 8'h05);
		wr_reg(8'h46, 8'hBF);
		wr_reg(8'h43, 8'h94);
		wait_clear(8'h04);
		chk("op", 16'h0001, {13'h0, op});
		chk("erase addr", 16'h0580, {1'b0, faddr});
		dly <= 8'h03;
		wr_reg(8'h46, 8'hBF);
		wr_reg(8'h43, 8'hB3);
		wait_clear(8'h01);
		chk("op", 16'h0003, {13'h0, op});
		rd_chk(8'h48, 8'hFF);
		rd_chk(8'h49, 8'hFF);
		wr_reg(8'h46, 8'hC0);
		wr_reg(8'h43, 8'hB3);
		wait_clear(8'h01);
		rd_chk(8'h48, 8'hC0);
		rd_chk(8'h49, 8'h65);
		wr_reg(8'h46, 8'h90);
		wr_reg(8'h48, 8'hCD);
		wr_reg(8'h49, 8'hAB);
		wr_reg(8'h43, 8'h84);
		wait_clear(8'h04);
		chk("op", 16'h0000, {13'h0, op});
		chk("requests", 16'h0004, 16'(nreq));
		// Read the written word back over a stale low byte to prove it reached the array.
		wr_reg(8'h48, 8'h00);
		wr_reg(8'h46, 8'h91);
		wr_reg(8'h43, 8'hB3);
		wait_clear(8'h01);
		rd_chk(8'h48, 8'hCD);
		rd_chk(8'h49, 8'hAB);
		chk("requests", 16'h0005, 16'(nreq));
		wr_reg(8'h45, 8'h01);
		chk("buffer clear", 16'h0001, {15'h0, clr});
		@(posedge clk_sys_in);
		#1 chk("buffer", 16'h0000, wbd);
		wr_reg(8'h44, 8'h55);
		chk("chip reset", 16'h0001, {15'h0, crst});
		rd_chk(8'h44, 8'h55);
		results();
	end
endmodule
`default_nettype wire
